/* hdl/mac_pkg.sv */
// mac_pkg: constants, opcodes and the adder function for the add-and-call datapath.
// assumes one 100 MHz clock and a plain register port with 4-bit addresses.
package mac_pkg;

  // register port layout
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;      // bit 0: table high option
  localparam logic [3:0] REG_FLAGS = 4'h1;     // carry, nibble, zero, signed wrap
  localparam logic [3:0] REG_WORK = 4'h2;      // work register
  localparam logic [3:0] REG_TBL_LO = 4'h3;    // table low pointer
  localparam logic [3:0] REG_TBL_HI = 4'h4;    // table high pointer, 5 bits
  localparam logic [3:0] REG_PC_LO = 4'h5;     // program counter low, read only
  localparam logic [3:0] REG_PC_HI = 4'h6;     // program counter high, read only
  localparam logic [3:0] REG_MEM_ADDR = 4'h7;  // memory window address
  localparam logic [3:0] REG_MEM_DATA = 4'h8;  // memory window data
  localparam logic [3:0] REG_STATUS = 4'h9;    // busy and stack depth, read only
  localparam logic [3:0] REG_STK_LO = 4'hA;    // last pushed return address low
  localparam logic [3:0] REG_STK_HI = 4'hB;    // last pushed return address high

  // field positions in the flag, control and status registers
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned CTRL_TBHI = 0;
  localparam int unsigned STAT_BUSY = 7;

  // sizes and reset values
  localparam int unsigned PC_W = 13;
  localparam int unsigned MEM_DEPTH = 216;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] TBL_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADC_W,
    OP_ADC_M,
    OP_ADD_W,
    OP_ADD_I,
    OP_ADD_M,
    OP_AND_W,
    OP_AND_I,
    OP_AND_M,
    OP_CALL,
    OP_CLR,
    OP_TAB
  } mac_op_t;

  typedef enum logic {
    ST_READY,
    ST_CALL_LOAD
  } mac_state_t;

  // 8-bit add: returns {signed wrap, nibble carry, carry, sum}
  function automatic logic [10:0] mac_add8(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [7:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    s = {hi[3:0], lo[3:0]};
    return {(a[7] == b[7]) && (s[7] != a[7]), lo[4], hi[4], s};
  endfunction

endpackage

/* hdl/mac_stack.sv */
// mac_stack: eight-level return address stack, push only.
// assumes pushes come from the datapath one cycle long; oldest entry is overwritten.
`timescale 1ns/1ns
`default_nettype none
module mac_stack import mac_pkg::*; (
  input wire logic i_clk,               // core clock
  input wire logic i_reset,             // async reset, active high
  input wire logic i_push,              // one-cycle push strobe
  input wire logic [12:0] i_data,       // return address to store
  output logic [3:0] o_depth,           // entries held, saturates at 8
  output logic [12:0] o_top             // last value pushed
);

  logic [12:0] slot [STACK_DEPTH];
  logic [2:0] wr_ptr;

  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      slot[wr_ptr] <= i_data;
    end
  end

  // pointer, depth and top copy
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr <= 3'h0;
      o_depth <= 4'h0;
      o_top <= 13'h0000;
    end else if (i_push) begin
      wr_ptr <= wr_ptr + 3'h1;
      o_top <= i_data;
      if (o_depth != 4'h8) begin
        o_depth <= o_depth + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/mac_exec.sv */
// mac_exec: execution datapath for add, and, call, memory clear and table address.
// assumes ops arrive one per cycle with i_op_valid, and are held off while o_busy.
//
// How it works
// [RULE1] add-with-carry: work plus memory plus carry into work, four flags
// [RULE2] add-with-carry: work plus memory plus carry into memory, four flags
// [RULE3] plain add: work plus memory into work, four flags
// [RULE4] immediate add: work plus literal into work, four flags
// [RULE5] plain add: work plus memory into memory, four flags
// [RULE6] and with memory into work, only zero flag changes
// [RULE7] and with literal into work, only zero flag changes
// [RULE8] and with work into memory, only zero flag changes
// [RULE9] call pushes pc plus one, loads target, flags untouched
// [RULE10] call takes two cycles
// [RULE11] clear writes 00 into the addressed memory byte
// [RULE12] table fetch uses both pointers when option set, else current page
// [RULE13] zero, carry out of bit 7, carry out of bit 3, signed overflow
`timescale 1ns/1ns
`default_nettype none
module mac_exec import mac_pkg::*; (
  input wire logic i_clk,               // core clock, 100 MHz
  input wire logic i_reset,             // async reset, active high
  input wire logic i_op_valid,          // op present this cycle
  input wire mac_op_t i_op,             // operation code
  input wire logic [7:0] i_mem_addr,    // data memory byte address
  input wire logic [7:0] i_imm,         // literal operand
  input wire logic [12:0] i_target,     // call target address
  input wire logic [3:0] i_addr,        // register address
  input wire logic [7:0] i_wdata,       // register write data
  input wire logic i_wr,                // register write strobe
  input wire logic i_rd,                // register read strobe
  output logic [7:0] o_rdata,           // read data, cycle after i_rd
  output logic o_busy,                  // call in its second cycle
  output logic [12:0] o_pc,             // program counter
  output logic o_rom_req,               // table fetch address valid pulse
  output logic [12:0] o_rom_addr        // table fetch program address
);

  logic [7:0] data_mem [MEM_DEPTH];
  logic [7:0] work_register;
  logic carry_flag;
  logic nibble_carry_flag;
  logic zero_flag;
  logic signed_wrap_flag;
  logic table_high_option;
  logic [7:0] table_low_pointer;
  logic [4:0] table_high_pointer;
  logic [7:0] mem_window_addr;
  logic [12:0] pc;
  logic [12:0] call_target;
  mac_state_t state;
  logic [3:0] stack_depth;
  logic [12:0] stack_top;

  // op decode
  wire go = i_op_valid && (state == ST_READY);
  wire op_adc = (i_op == OP_ADC_W) || (i_op == OP_ADC_M);
  wire op_add = op_adc || (i_op == OP_ADD_W) || (i_op == OP_ADD_I) || (i_op == OP_ADD_M);
  wire op_and = (i_op == OP_AND_W) || (i_op == OP_AND_I) || (i_op == OP_AND_M);
  wire op_imm = (i_op == OP_ADD_I) || (i_op == OP_AND_I);
  wire op_to_mem = (i_op == OP_ADC_M) || (i_op == OP_ADD_M) || (i_op == OP_AND_M)
                   || (i_op == OP_CLR);
  wire op_to_work = (i_op == OP_ADC_W) || (i_op == OP_ADD_W) || (i_op == OP_ADD_I)
                    || (i_op == OP_AND_W) || (i_op == OP_AND_I);
  wire op_call = i_op == OP_CALL;
  wire op_tab = i_op == OP_TAB;

  // operand fetch; bytes past the end read as zero
  wire mem_ok = i_mem_addr < 8'(MEM_DEPTH);
  wire [7:0] mem_rd = mem_ok ? data_mem[i_mem_addr] : 8'h00;
  wire [7:0] operand_b = op_imm ? i_imm : mem_rd;
  wire carry_in = op_adc && carry_flag; // see [RULE1] see [RULE2]

  // arithmetic and logic results
  wire [10:0] add_out = mac_add8(work_register, operand_b, carry_in); // see [RULE13]
  wire [7:0] and_out = work_register & operand_b;
  wire [7:0] result = op_and ? and_out : ((i_op == OP_CLR) ? 8'h00 : add_out[7:0]);
  wire result_zero = result == 8'h00;

  // write enables
  wire work_we = go && op_to_work; // see [RULE1] see [RULE3] see [RULE4] see [RULE6] see [RULE7]
  wire mem_we = go && op_to_mem && mem_ok; // see [RULE2] see [RULE5] see [RULE8] see [RULE11]
  wire win_ok = mem_window_addr < 8'(MEM_DEPTH);
  wire win_we = i_wr && (i_addr == REG_MEM_DATA) && win_ok && !(go && op_to_mem);
  wire sw_wr = i_wr && !go;

  // table fetch address
  wire [12:0] rom_addr_sel = table_high_option ? {table_high_pointer, table_low_pointer}
                                               : {pc[12:8], table_low_pointer}; // see [RULE12]

  // register read selection
  wire [7:0] win_rd = win_ok ? data_mem[mem_window_addr] : 8'h00;
  wire [7:0] flags_rd = {4'h0, signed_wrap_flag, zero_flag, nibble_carry_flag, carry_flag};
  wire [7:0] rd_mux =
    (i_addr == REG_CTRL) ? {7'h00, table_high_option} :
    (i_addr == REG_FLAGS) ? flags_rd :
    (i_addr == REG_WORK) ? work_register :
    (i_addr == REG_TBL_LO) ? table_low_pointer :
    (i_addr == REG_TBL_HI) ? {3'h0, table_high_pointer} :
    (i_addr == REG_PC_LO) ? pc[7:0] :
    (i_addr == REG_PC_HI) ? {3'h0, pc[12:8]} :
    (i_addr == REG_MEM_ADDR) ? mem_window_addr :
    (i_addr == REG_MEM_DATA) ? win_rd :
    (i_addr == REG_STATUS) ? {o_busy, 3'h0, stack_depth} :
    (i_addr == REG_STK_LO) ? stack_top[7:0] :
    (i_addr == REG_STK_HI) ? {3'h0, stack_top[12:8]} : 8'h00;

  // return stack
  mac_stack u_stack (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_push(go && op_call), // see [RULE9]
    .i_data(pc + 13'h0001),
    .o_depth(stack_depth),
    .o_top(stack_top)
  );

  // data memory: op write wins over window write
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      data_mem[i_mem_addr] <= result;
    end else if (win_we) begin
      data_mem[mem_window_addr] <= i_wdata;
    end
  end

  // work register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      work_register <= WORK_RESET;
    end else if (work_we) begin
      work_register <= result;
    end else if (sw_wr && i_addr == REG_WORK) begin
      work_register <= i_wdata;
    end
  end

  // flags: add sets four, and sets only zero, call and clear leave them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {signed_wrap_flag, zero_flag, nibble_carry_flag, carry_flag} <= FLAGS_RESET;
    end else if (go && op_add) begin
      carry_flag <= add_out[8]; // see [RULE13]
      nibble_carry_flag <= add_out[9];
      signed_wrap_flag <= add_out[10];
      zero_flag <= result_zero;
    end else if (go && op_and) begin
      zero_flag <= result_zero; // see [RULE6] see [RULE7] see [RULE8]
    end else if (sw_wr && i_addr == REG_FLAGS) begin
      carry_flag <= i_wdata[FLAG_C];
      nibble_carry_flag <= i_wdata[FLAG_AC];
      zero_flag <= i_wdata[FLAG_Z];
      signed_wrap_flag <= i_wdata[FLAG_OV];
    end
  end

  // software control registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      table_high_option <= 1'b0;
      table_low_pointer <= TBL_RESET;
      table_high_pointer <= 5'h00;
      mem_window_addr <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) table_high_option <= i_wdata[CTRL_TBHI];
      if (i_addr == REG_TBL_LO) table_low_pointer <= i_wdata;
      if (i_addr == REG_TBL_HI) table_high_pointer <= i_wdata[4:0];
      if (i_addr == REG_MEM_ADDR) mem_window_addr <= i_wdata;
    end
  end

  // sequencer: call holds for a second cycle to load the target
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_READY;
      pc <= PC_RESET;
      call_target <= 13'h0000;
      o_busy <= 1'b0;
    end else begin
      unique case (state)
        ST_READY: begin
          if (go && op_call) begin
            call_target <= i_target;
            state <= ST_CALL_LOAD; // see [RULE10]
            o_busy <= 1'b1;
          end else if (go) begin
            pc <= pc + 13'h0001;
          end
        end
        ST_CALL_LOAD: begin
          pc <= call_target; // see [RULE9]
          state <= ST_READY;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  assign o_pc = pc;

  // table fetch address and read data
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rom_req <= 1'b0;
      o_rom_addr <= 13'h0000;
      o_rdata <= 8'h00;
    end else begin
      o_rom_req <= go && op_tab;
      if (go && op_tab) o_rom_addr <= rom_addr_sel;
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  wire [8:0] wide_sum = {1'b0, work_register} + {1'b0, operand_b} + {8'h00, carry_in};
  wire [4:0] low_sum = {1'b0, work_register[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, carry_in};

  a_adc_work_sum: assert property (go && i_op == OP_ADC_W |=> // see [RULE1]
    work_register == 8'($past(work_register) + $past(mem_rd) + {7'h00, $past(carry_flag)}))
    else $error("adc to work wrong");
  a_adc_mem_sum: assert property (go && i_op == OP_ADC_M && mem_ok |=> // see [RULE2]
    data_mem[$past(i_mem_addr)] == 8'($past(wide_sum)) && work_register == $past(work_register))
    else $error("adc to memory wrong");
  a_add_work_sum: assert property (go && i_op == OP_ADD_W |=> // see [RULE3]
    work_register == 8'($past(work_register) + $past(mem_rd)))
    else $error("add to work wrong");
  a_add_imm_sum: assert property (go && i_op == OP_ADD_I |=> // see [RULE4]
    work_register == 8'($past(work_register) + $past(i_imm)))
    else $error("immediate add wrong");
  a_add_mem_sum: assert property (go && i_op == OP_ADD_M && mem_ok |=> // see [RULE5]
    data_mem[$past(i_mem_addr)] == 8'($past(work_register) + $past(mem_rd)))
    else $error("add to memory wrong");
  a_and_work_zero: assert property (go && i_op == OP_AND_W |=> // see [RULE6]
    work_register == ($past(work_register) & $past(mem_rd))
    && zero_flag == (work_register == 8'h00) && $stable(carry_flag)
    && $stable(signed_wrap_flag))
    else $error("and to work wrong");
  a_and_imm_flags: assert property (go && i_op == OP_AND_I |=> // see [RULE7]
    work_register == ($past(work_register) & $past(i_imm)) && $stable(nibble_carry_flag))
    else $error("and literal wrong");
  a_and_mem_zero: assert property (go && i_op == OP_AND_M && mem_ok |=> // see [RULE8]
    data_mem[$past(i_mem_addr)] == ($past(work_register) & $past(mem_rd))
    && zero_flag == ($past(work_register & mem_rd) == 8'h00) && $stable(carry_flag))
    else $error("and to memory wrong");
  a_call_push_load: assert property (go && op_call |=> // see [RULE9]
    stack_top == $past(pc) + 13'h0001 && $stable(carry_flag) ##1 pc == $past(i_target, 2))
    else $error("call push or load wrong");
  a_call_two_cycles: assert property (go && op_call |=> // see [RULE10]
    o_busy && $stable(pc) ##1 !o_busy)
    else $error("call not two cycles");
  a_clear_mem_byte: assert property (go && i_op == OP_CLR && mem_ok |=> // see [RULE11]
    data_mem[$past(i_mem_addr)] == 8'h00 && $stable(zero_flag))
    else $error("clear left data");
  a_table_addr_form: assert property (go && op_tab |=> o_rom_req && // see [RULE12]
    o_rom_addr == ($past(table_high_option) ? $past({table_high_pointer, table_low_pointer})
                                            : $past({pc[12:8], table_low_pointer})))
    else $error("table address wrong");
  a_add_flag_values: assert property (go && op_add |=> // see [RULE13]
    carry_flag == $past(wide_sum[8]) && nibble_carry_flag == $past(low_sum[4])
    && zero_flag == ($past(wide_sum[7:0]) == 8'h00)
    && signed_wrap_flag == $past((work_register[7] == operand_b[7])
                                 && (wide_sum[7] != work_register[7])))
    else $error("add flags wrong");

endmodule
`default_nettype wire

/* sim/tb_mac_exec.sv */
// tb_mac_exec: self-checking bench for the add-and-call datapath.
// assumes mac_pkg and mac_exec compiled first; one 100 MHz clock, no partner.
`timescale 1ns/1ns
`default_nettype none
module tb_mac_exec import mac_pkg::*; ();
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_op_valid = 1'b0;
  mac_op_t i_op = OP_NOP;
  logic [7:0] i_mem_addr = 8'h00;
  logic [7:0] i_imm = 8'h00;
  logic [12:0] i_target = 13'h0000;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_busy;
  logic [12:0] o_pc;
  logic o_rom_req;
  logic [12:0] o_rom_addr;
  // bench model of the datapath state
  logic [7:0] m_work = 8'h00;
  logic [3:0] m_flags = 4'h0;
  logic [7:0] m_mem [0:7];
  logic [12:0] m_pc = 13'h0000;
  logic [7:0] m_tlo = 8'h00;
  logic [4:0] m_thi = 5'h00;
  logic m_opt = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rq [$];
  logic [12:0] romq [$];
  int fails = 0;
  int checks_done = 0;
  mac_op_t ops [9] = '{OP_ADC_W, OP_ADC_M, OP_ADD_W, OP_ADD_I, OP_ADD_M, OP_AND_W, OP_AND_I,
                       OP_AND_M, OP_CLR};

  mac_exec dut (.i_clk(i_clk), .i_reset(i_reset), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_mem_addr(i_mem_addr), .i_imm(i_imm), .i_target(i_target), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy),
    .o_pc(o_pc), .o_rom_req(o_rom_req), .o_rom_addr(o_rom_addr));

  // clock generator
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic end_of_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: address %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle register write, strobe dropped at the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // one-cycle register read; expected byte queued for the monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    rq.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  // reference add: {wrap, zero, nibble, carry, sum}
  function automatic logic [11:0] add_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, n[4], s[8], s[7:0]};
  endfunction

  // issue one op and advance the model
  task automatic op(input mac_op_t o, input logic [2:0] ma, input logic [7:0] im);
    logic [11:0] r;
    logic [7:0] b;
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= o;
    i_mem_addr <= {5'h00, ma};
    i_imm <= im;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    b = (o == OP_ADD_I || o == OP_AND_I) ? im : m_mem[ma];
    r = add_ref(m_work, b, (o == OP_ADC_W || o == OP_ADC_M) ? m_flags[FLAG_C] : 1'b0);
    case (o)
      OP_ADC_W, OP_ADD_W, OP_ADD_I: {m_flags, m_work} = r;
      OP_ADC_M, OP_ADD_M: {m_flags, m_mem[ma]} = r;
      OP_AND_W, OP_AND_I: m_work = m_work & b;
      OP_AND_M: m_mem[ma] = m_work & b;
      OP_CLR: m_mem[ma] = 8'h00;
      OP_TAB: romq.push_back(m_opt ? {m_thi, m_tlo} : {m_pc[12:8], m_tlo});
      default: ;
    endcase
    if (o == OP_AND_W || o == OP_AND_I) m_flags[FLAG_Z] = (m_work == 8'h00);
    if (o == OP_AND_M) m_flags[FLAG_Z] = (m_mem[ma] == 8'h00);
    m_pc = m_pc + 13'h0001;
  endtask

  // read back work, flags and one memory byte
  task automatic check_state(input logic [2:0] ma);
    rd(REG_WORK, m_work);
    rd(REG_FLAGS, {4'h0, m_flags});
    wr(REG_MEM_ADDR, {5'h00, ma});
    rd(REG_MEM_DATA, m_mem[ma]);
  endtask

  // monitor: read data and table addresses against the oldest notes
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) begin
    if (rd_d) chk8(o_rdata, rq.pop_front());
    if (o_rom_req === 1'b1) chk13(o_rom_addr, romq.pop_front());
  end

  // watchdog, far beyond the expected run
  initial begin
    #300000;
    fails++;
    end_of_test();
  end

  initial begin
    logic [2:0] ma;
    logic [12:0] tgt;
    void'($urandom(4263));
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    // reset values, read-only and unmapped places
    rd(REG_WORK, WORK_RESET);
    rd(REG_FLAGS, 8'h00);
    wr(REG_PC_LO, 8'hA5);
    rd(REG_PC_LO, 8'h00);
    rd(REG_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      m_mem[i] = (i == 0) ? 8'h01 : 8'($urandom);
      wr(REG_MEM_ADDR, 8'(i));
      wr(REG_MEM_DATA, m_mem[i]);
    end
    // wrap to zero: carry, nibble carry and zero all set
    m_work = 8'hFF;
    wr(REG_WORK, m_work);
    op(OP_ADD_W, 3'd0, 8'h00);
    check_state(3'd0);
    // every data op with random operands and carry-in
    for (int i = 0; i < 63; i++) begin
      ma = 3'($urandom_range(0, 7));
      m_work = 8'($urandom);
      m_flags = 4'($urandom);
      wr(REG_WORK, m_work);
      wr(REG_FLAGS, {4'h0, m_flags});
      op(ops[i % 9], ma, 8'($urandom)); // to
      check_state(ma);
    end
    chk13(o_pc, m_pc);
    // call with an op held on through the busy cycle, which is dropped
    tgt = 13'($urandom);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= OP_CALL;
    i_target <= tgt;
    @(posedge i_clk);
    i_op <= OP_ADD_I;
    i_imm <= 8'h55;
    @(negedge i_clk);
    chk8({7'h00, o_busy}, 8'h01);
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    @(negedge i_clk);
    chk13(o_pc, tgt);
    chk8({7'h00, o_busy}, 8'h00);
    m_pc = m_pc + 13'h0001;
    rd(REG_STK_LO, m_pc[7:0]);
    rd(REG_STK_HI, {3'h0, m_pc[12:8]});
    rd(REG_STATUS, 8'h01);
    rd(REG_FLAGS, {4'h0, m_flags});
    rd(REG_WORK, m_work);
    m_pc = tgt;
    // table fetch from the current page, then from both pointers
    m_tlo = 8'($urandom);
    m_thi = 5'($urandom);
    wr(REG_TBL_LO, m_tlo);
    wr(REG_TBL_HI, {3'h0, m_thi});
    op(OP_TAB, 3'd0, 8'h00);
    m_opt = 1'b1;
    wr(REG_CTRL, 8'h01);
    op(OP_TAB, 3'd0, 8'h00);
    repeat (3) @(posedge i_clk);
    chk13(o_pc, m_pc);
    end_of_test();
  end
endmodule
`default_nettype wire
